// ==== gptu_assertions.sv ====
// gptu_assertions.sv: bus and timing checker for the timer unit
// assumes: bound to gptu_top; ce held high while bus traffic runs
`timescale 1ns/1ps
`default_nettype none
module gptu_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        ce,
  input wire logic        srst,
  // register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // outputs
  input wire logic        core_toggle_latch,
  input wire logic        irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // bus steps
  sequence s_wr_take;
    ce && awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wr_answer;
    !awready && !wready ##1 bvalid;
  endsequence
  sequence s_rd_take;
    ce && arvalid && arready;
  endsequence

  // write channel
  a_write_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write answer not on time");
  a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted during response");
  // read channel
  a_read_answer: assert property (s_rd_take |=> rvalid && !arready)
    else $error("read answer not on time");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped early");
  a_read_err: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0)
    else $error("refused read carries data");
  // state at reset release
  a_reset_state: assert property ($fell(srst) |-> awready && arready && !bvalid && !rvalid
                                  && !irq && !core_toggle_latch)
    else $error("outputs wrong after reset");
  // latch moves once per base tick at most
  a_latch_spacing: assert property ($changed(core_toggle_latch) |=>
                                    $stable(core_toggle_latch)[*7])
    else $error("toggle latch changed too soon");
  // interrupt only drops on a register write
  a_irq_fall: assert property ($fell(irq) |-> $rose(bvalid))
    else $error("interrupt dropped without write");
endmodule

bind gptu_top gptu_checker i_chk (
  .clk, .ce, .srst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .core_toggle_latch, .irq
);
`default_nettype wire

// ==== gptu_cnt.v ====
// gptu_cnt.v: one 16-bit up/down count register with load and wrap flag
// assumes: step and load come from logic on clk; load wins over step
`timescale 1ns/1ps
`default_nettype none
`include "gptu_map.vh"
module gptu_cnt (
  // clock, enable, reset
  input  wire        clk,
  input  wire        ce,
  input  wire        srst,
  // control
  input  wire        step,
  input  wire        down,
  input  wire        load,
  input  wire [15:0] load_val,
  // state
  output reg  [15:0] value,
  output wire        wrap
);
  // wrap is a pulse in the cycle the count passes max to zero or back
  assign wrap = step & ~load &
                (down ? (value == `GPTU_CNT_MIN) : (value == `GPTU_CNT_MAX));

  // count register
  always @(posedge clk) begin
    if (srst) begin
      value <= `GPTU_CNT_MIN;
    end else if (ce) begin
      if (load) begin
        value <= load_val;
      end else if (step) begin
        value <= down ? value - `GPTU_CNT_ONE : value + `GPTU_CNT_ONE;
      end
    end
  end
endmodule
`default_nettype wire

// ==== gptu_map.vh ====
// gptu_map.vh: register map, field positions, codes and timing of the timer unit
// assumes: included by the timer unit design files, definitions only
`ifndef GPTU_MAP_VH
`define GPTU_MAP_VH

// byte offsets on the register bus
`define GPTU_A_CTRL0    8'h00
`define GPTU_A_CTRL1    8'h04
`define GPTU_A_CTRL2    8'h08
`define GPTU_A_VAL0     8'h0c
`define GPTU_A_VAL1     8'h10
`define GPTU_A_VAL2     8'h14
`define GPTU_A_STAT     8'h18
`define GPTU_A_MASK     8'h1c
`define GPTU_A_SET      8'h20
`define GPTU_A_PINS     8'h24

// control register fields, one control register per timer
`define GPTU_CW         20
`define GPTU_F_MODE     1:0
`define GPTU_F_PRE      4:2
`define GPTU_F_RUN      5
`define GPTU_F_DOWN     6
`define GPTU_F_XDIR     7
`define GPTU_F_EDGE     9:8
`define GPTU_F_GLVL     10
`define GPTU_F_FUNC     12:11
`define GPTU_F_LSRC     13
`define GPTU_F_RSEL     15:14
`define GPTU_F_PRIO     19:16
`define GPTU_CTRL_RST   20'h00000

// mode, auxiliary function and answer codes
`define GPTU_M_TIMER    2'h0
`define GPTU_M_GATED    2'h1
`define GPTU_M_COUNT    2'h2
`define GPTU_M_INCR     2'h3
`define GPTU_FN_NORM    2'h0
`define GPTU_FN_RELOAD  2'h1
`define GPTU_FN_CAPT    2'h2
`define GPTU_RESP_OK    2'h0
`define GPTU_RESP_ERR   2'h2

// counter limits and resolution timing
`define GPTU_CNT_MIN    16'h0000
`define GPTU_CNT_MAX    16'hffff
`define GPTU_CNT_ONE    16'h0001
`define GPTU_RES_TCL    16
`define GPTU_TCL_PER_CLK 2
`define GPTU_RES_CYC    (`GPTU_RES_TCL / `GPTU_TCL_PER_CLK)
`endif

// ==== gptu_pin_model.sv ====
// gptu_pin_model.sv: pin-side model: gate levels, event pulses, sensor a/b
// assumes: driven from the bench by task calls, pins change after clk edges
`timescale 1ns/1ps
`default_nettype none
module gptu_pin_model (
  // clock
  input  wire logic       clk,
  // pins toward the unit
  output var  logic [2:0] tin,
  output var  logic [2:0] tdir
);
  // pins start low
  initial begin
    tin = 3'h0;
    tdir = 3'h0;
  end
  // set one input pin level
  task automatic set_in(input int i, input logic v);
    @(posedge clk);
    tin[i] <= v;
  endtask
  // one event pulse, spaced wider than a base tick
  task automatic pulse(input int i);
    set_in(i, 1'b1);
    repeat (12) @(posedge clk);
    set_in(i, 1'b0);
    repeat (12) @(posedge clk);
  endtask
  // one sensor cycle on bit 0, a leads b when fwd
  task automatic quad(input logic fwd);
    logic [7:0] pat;
    pat = fwd ? 8'hb4 : 8'h78;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      {tin[0], tdir[0]} <= pat[7 - 2 * k -: 2];
      repeat (16) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ==== gptu_sync.v ====
// gptu_sync.v: two flip-flop synchroniser for pin inputs
// assumes: inputs asynchronous to clk; only q is read by other logic
`timescale 1ns/1ps
`default_nettype none
module gptu_sync #(
  parameter W = 1
) (
  // clock, enable, reset
  input  wire         clk,
  input  wire         ce,
  input  wire         srst,
  // data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (srst) begin
      meta_reg <= {W{1'b0}};
      q        <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ==== gptu_test.sv ====
// gptu_test.sv: self-checking bench for the timer unit
// assumes: gptu_top, gptu_pin_model and the checker bind are compiled
`timescale 1ns/1ps
`default_nettype none
`include "gptu_map.vh"
module gptu_test;
  typedef struct {logic we; logic [7:0] a; logic [31:0] d; logic [1:0] br;
                  logic [31:0] rd; logic [1:0] rr;} gptu_row_t;
  logic        clk, ce, srst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, core_toggle_latch, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [15:0] dv;
  wire  [2:0]  tin, tdir;
  int          n_mismatch, num_checks;
  gptu_row_t   rows [9] = '{
    '{1'b0, `GPTU_A_CTRL0, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'b0, `GPTU_A_STAT, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'b0, `GPTU_A_PINS, 32'h0, 2'h0, 32'h0, 2'h0},
    '{1'b1, `GPTU_A_VAL1, 32'h11234, 2'h0, 32'h1234, 2'h0},
    '{1'b1, `GPTU_A_CTRL2, 32'hf0000, 2'h0, 32'hf0000, 2'h0},
    '{1'b1, `GPTU_A_MASK, 32'h5, 2'h0, 32'h5, 2'h0},
    '{1'b1, `GPTU_A_PINS, 32'hff, 2'h0, 32'h0, 2'h0},
    '{1'b1, 8'h28, 32'h1, 2'h2, 32'h0, 2'h2},
    '{1'b1, 8'h02, 32'h1, 2'h2, 32'h0, 2'h2}};

  gptu_top i_dut (
    .clk, .ce, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .timer_input_pin(tin), .direction_input_pin(tdir), .core_toggle_latch, .irq);
  gptu_pin_model i_pins (.clk, .tin, .tdir);

  // 125 mhz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  // report, compare, bus tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait ran out
  task automatic hang(input int k);
    if (k >= 50) begin
      chk("timeout", 32'h0, 32'h1);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit aw, w;
    int k;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 0;
    w = 0;
    for (k = 0; k < 50 && !(aw && w); k++) begin
      @(posedge clk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    hang(k);
    for (k = 0; k < 50 && !bvalid; k++) @(posedge clk);
    hang(k);
    bready <= 1'b1;
    @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int k;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50 && !arready; k++) @(posedge clk);
    hang(k);
    @(posedge clk);
    arvalid <= 1'b0;
    for (k = 0; k < 50 && !rvalid; k++) @(posedge clk);
    hang(k);
    rready <= 1'b1;
    @(posedge clk);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  // count change over exactly n clocks
  task automatic span(input logic [7:0] a, input int n);
    logic [31:0] v1, v2;
    rd(a, v1);
    repeat (n - 4) @(posedge clk);
    rd(a, v2);
    dv = v2[15:0] - v1[15:0];
  endtask

  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {ce, srst} = 2'h3;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    // register table
    foreach (rows[i]) begin
      if (rows[i].we) wr(rows[i].a, rows[i].d);
      if (rows[i].we) chk("bresp", rows[i].br, resp);
      rd(rows[i].a, v);
      chk("rdata", rows[i].rd, v);
      chk("rresp", rows[i].rr, resp);
    end
    // prescaled rate
    for (int p = 0; p < 3; p++) begin
      wr(`GPTU_A_CTRL0, 32'h20 | (p << 2));
      span(`GPTU_A_VAL0, 80 << p);
      chk("rate", 32'ha, dv);
    end
    // underflow, latch, flags, mask
    wr(`GPTU_A_VAL0, 32'h1);
    wr(`GPTU_A_MASK, 32'h1);
    wr(`GPTU_A_STAT, 32'h7);
    wr(`GPTU_A_CTRL0, 32'h60);
    begin : wait_wrap
      int k;
      for (k = 0; k < 50 && !core_toggle_latch; k++) @(posedge clk);
    end
    wr(`GPTU_A_CTRL0, 32'h0);
    chk("latch", 32'h1, core_toggle_latch);
    rd(`GPTU_A_VAL0, v);
    chk("down", 32'hffff, v);
    rd(`GPTU_A_STAT, v);
    chk("stat", 32'h1, v);
    chk("irq", 32'h1, irq);
    wr(`GPTU_A_MASK, 32'h0);
    chk("irq", 32'h0, irq);
    wr(`GPTU_A_MASK, 32'h1);
    wr(`GPTU_A_STAT, 32'h1);
    chk("irq", 32'h0, irq);
    wr(`GPTU_A_SET, 32'h2);
    rd(`GPTU_A_STAT, v);
    chk("set", 32'h2, v);
    chk("irq", 32'h0, irq);
    wr(`GPTU_A_STAT, 32'h2);
    // event counter on aux a
    wr(`GPTU_A_CTRL1, 32'h122);
    repeat (5) i_pins.pulse(1);
    rd(`GPTU_A_VAL1, v);
    chk("events", 32'h1239, v);
    wr(`GPTU_A_CTRL1, 32'h0);
    // gated timer on aux b
    wr(`GPTU_A_VAL2, 32'h0);
    wr(`GPTU_A_CTRL2, 32'h421);
    span(`GPTU_A_VAL2, 80);
    chk("gate shut", 32'h0, dv);
    i_pins.set_in(2, 1'b1);
    repeat (8) @(posedge clk);
    span(`GPTU_A_VAL2, 80);
    chk("gate open", 32'ha, dv);
    i_pins.set_in(2, 1'b0);
    // sensor tracking on core
    wr(`GPTU_A_VAL0, 32'h100);
    wr(`GPTU_A_CTRL0, 32'h23);
    i_pins.quad(1'b1);
    rd(`GPTU_A_VAL0, v);
    chk("fwd", 32'h104, v);
    i_pins.quad(1'b0);
    rd(`GPTU_A_VAL0, v);
    chk("back", 32'h100, v);
    // capture into aux b, reload from aux a
    wr(`GPTU_A_CTRL0, 32'h0);
    wr(`GPTU_A_VAL0, 32'h4321);
    wr(`GPTU_A_CTRL2, 32'h1120);
    i_pins.pulse(2);
    rd(`GPTU_A_VAL2, v);
    chk("capture", 32'h4321, v);
    span(`GPTU_A_VAL2, 80);
    chk("held", 32'h0, dv);
    wr(`GPTU_A_VAL1, 32'habcd);
    wr(`GPTU_A_CTRL1, 32'h920);
    i_pins.pulse(1);
    rd(`GPTU_A_VAL0, v);
    chk("reload", 32'habcd, v);
    // aux a counts latch edges, a latch rise reloads the core from aux b
    wr(`GPTU_A_CTRL1, 32'h2322);
    wr(`GPTU_A_VAL1, 32'h0);
    wr(`GPTU_A_CTRL2, 32'h4820);
    wr(`GPTU_A_CTRL0, 32'h122);
    repeat (2) begin
      wr(`GPTU_A_VAL0, 32'hffff);
      i_pins.pulse(0);
    end
    rd(`GPTU_A_VAL1, v);
    chk("latch count", 32'h2, v);
    rd(`GPTU_A_VAL0, v);
    chk("latch reload", 32'h4321, v);
    // reset in mid-run
    wr(`GPTU_A_CTRL0, 32'h20);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    rd(`GPTU_A_CTRL0, v);
    chk("ctrl rst", 32'h0, v);
    rd(`GPTU_A_VAL1, v);
    chk("val rst", 32'h0, v);
    chk("latch rst", 32'h0, core_toggle_latch);
    give_verdict();
  end
endmodule
`default_nettype wire

// ==== gptu_top.v ====
// gptu_top.v: three-timer unit (core timer, aux timer a, aux timer b) with
// an AXI4-Lite register slave and a level interrupt
// assumes: one clock; pins asynchronous; master keeps AXI4-Lite handshakes
//
// Overview of operation
// RQ1 - The unit holds three independent 16-bit count registers: core, aux a and aux b.
// RQ2 - Timers can work jointly: aux timers clock from, capture or reload the core timer.
// RQ3 - Each timer takes one of four modes: timer, gated timer, event counter, incremental.
// RQ4 - Timer mode counts the base tick divided by a software prescaler of 2 to the power 0..7.
// RQ5 - Event counter mode counts selected edges seen on the timer input pin.
// RQ6 - Gated timer mode counts prescaled ticks only while the input pin is at the gate level.
// RQ7 - No timer counts faster than one step per 16 state clock units, i.e. 8 clocks.
// RQ8 - Direction is a software bit, optionally inverted live by the direction pin.
// RQ9 - Incremental mode decodes sensor A and B into count steps and direction.
// RQ10 - The core toggle latch flips on every core overflow and underflow.
// RQ11 - An aux timer in counter mode can count edges of the core toggle latch.
// RQ12 - An aux timer set up to reload or capture stops counting.
// RQ13 - In capture, an edge on the aux input pin copies the core count into the aux timer.
// RQ14 - In reload, a pin edge or chosen latch edge loads the core from the aux timer.
// RQ15 - Each timer has a request flag, an enable bit and a priority field; software may set flags.
// RQ16 - A wrap sets that timer's request flag on the same clock edge as the wrap.
// RQ17 - All pin inputs pass two flip-flops before edge or level logic sees them.
`timescale 1ns/1ps
`default_nettype none
`include "gptu_map.vh"
module gptu_top (
  // clock, enable, reset
  input  wire        clk,
  input  wire        ce,
  input  wire        srst,
  // axi4-lite write address and data
  input  wire [7:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  // axi4-lite write response
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // axi4-lite read
  input  wire [7:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // timer pins, bit 0 core, bit 1 aux a, bit 2 aux b
  input  wire [2:0]  timer_input_pin,
  input  wire [2:0]  direction_input_pin,
  // outputs
  output reg         core_toggle_latch,
  output reg         irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  reg  [7:0]              awaddr_reg;
  reg  [31:0]             wdata_reg;
  reg  [3:0]              wstrb_reg;
  reg  [3*`GPTU_CW-1:0]   ctrl_reg;
  reg  [2:0]              stat_reg;
  reg  [2:0]              mask_reg;
  reg  [2:0]              in_prev_reg;
  reg  [2:0]              dir_prev_reg;
  reg                     latch_prev_reg;
  reg  [3:0]              base_reg;
  reg  [7:0]              pre_reg;
  reg  [31:0]             rd_next;
  reg                     rd_hit;
  wire [2:0]              in_s;
  wire [2:0]              dir_s;
  wire [47:0]             val_flat;
  wire [2:0]              wrap;
  wire [2:0]              reload_req;
  wire [31:0]             wmask;
  wire                    wr_go;
  wire                    wr_hit;
  wire [2:0]              wr_ctrl;
  wire [2:0]              wr_val;
  wire                    base_tick;
  wire                    lat_rise;
  wire                    lat_fall;
  wire [2:0]              stat_next;
  integer                 k;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  gptu_sync #(.W(6)) u_sync (
    .clk  (clk),
    .ce   (ce),
    .srst (srst),
    .d    ({direction_input_pin, timer_input_pin}),
    .q    ({dir_s, in_s})
  ); // see RQ17

  // previous synced levels for edge detection
  always @(posedge clk) begin
    if (srst) begin
      in_prev_reg    <= 3'h0;
      dir_prev_reg   <= 3'h0;
      latch_prev_reg <= 1'b0;
    end else if (ce) begin
      in_prev_reg    <= in_s;
      dir_prev_reg   <= dir_s;
      latch_prev_reg <= core_toggle_latch;
    end
  end

  assign lat_rise = core_toggle_latch & ~latch_prev_reg;
  assign lat_fall = ~core_toggle_latch & latch_prev_reg;

  ////////////////////////////////////////////////////////////////////////////
  // base tick every 8 clocks and prescale counter
  assign base_tick = ({28'h0000000, base_reg} == `GPTU_RES_CYC - 1); // see RQ7

  always @(posedge clk) begin
    if (srst) begin
      base_reg <= 4'h0;
      pre_reg  <= 8'h00;
    end else if (ce) begin
      base_reg <= base_tick ? 4'h0 : base_reg + 4'h1;
      if (base_tick) begin
        pre_reg <= pre_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-timer step, direction and load logic
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_tmr
      wire [`GPTU_CW-1:0] c = ctrl_reg[i*`GPTU_CW +: `GPTU_CW];
      wire [15:0] v = val_flat[i*16 +: 16];
      wire [7:0]  pmask = (8'h01 << c[`GPTU_F_PRE]) - 8'h01;
      wire        ptick = base_tick & ((pre_reg | ~pmask) == 8'hff); // see RQ4
      wire        rise  = in_s[i] & ~in_prev_reg[i];
      wire        fall  = ~in_s[i] & in_prev_reg[i];
      wire        ev_pin = (c[8] & rise) | (c[9] & fall);
      wire        ev_lat = (c[8] & lat_rise) | (c[9] & lat_fall);
      wire        use_lat = (i != 0) & c[`GPTU_F_LSRC];
      wire        ev = use_lat ? ev_lat : ev_pin; // see RQ5, RQ11
      wire        qa = in_s[i] ^ in_prev_reg[i];
      wire        qb = dir_s[i] ^ dir_prev_reg[i];
      wire        qdown = qa ? (in_s[i] == dir_s[i]) : (in_s[i] != dir_s[i]);
      wire        incr = (c[`GPTU_F_MODE] == `GPTU_M_INCR);
      wire        cnt_ev = incr ? (qa | qb) : ev; // see RQ9
      wire        sdown = c[`GPTU_F_XDIR] ? (c[`GPTU_F_DOWN] ^ dir_s[i])
                                          : c[`GPTU_F_DOWN]; // see RQ8
      wire [1:0]  fn = (i == 0) ? `GPTU_FN_NORM : c[`GPTU_F_FUNC];
      wire        stopped = ~c[`GPTU_F_RUN] | (fn != `GPTU_FN_NORM); // see RQ12
      wire        is_cnt = (c[`GPTU_F_MODE] == `GPTU_M_COUNT) | incr;
      wire        consume = base_tick & ~stopped & is_cnt;
      wire        capt = (fn == `GPTU_FN_CAPT) & ev_pin; // see RQ13
      wire        rl_lat = (c[14] & lat_rise) | (c[15] & lat_fall);
      wire        rl_ev = (c[`GPTU_F_RSEL] == 2'h0) ? ev_pin : rl_lat;
      wire [15:0] sw_val = (v & ~wmask[15:0]) | (wdata_reg[15:0] & wmask[15:0]);
      reg         pend_reg;
      reg         pdown_reg;
      reg         step;
      reg         down;
      reg         load;
      reg  [15:0] load_val;

      // pending count event, only kept in counting modes so no stale step survives
      always @(posedge clk) begin
        if (srst) begin
          pend_reg  <= 1'b0;
          pdown_reg <= 1'b0;
        end else if (ce) begin
          if (cnt_ev && is_cnt) begin
            pend_reg  <= 1'b1;
            pdown_reg <= incr ? qdown : sdown;
          end else if (consume || !is_cnt) begin
            pend_reg  <= 1'b0;
          end
        end
      end

      assign reload_req[i] = (fn == `GPTU_FN_RELOAD) & rl_ev; // see RQ14

      // step selection by mode, at most one step per base tick
      always @(*) begin
        step = 1'b0;
        down = sdown;
        case (c[`GPTU_F_MODE])
          `GPTU_M_TIMER: begin
            step = ptick;
          end
          `GPTU_M_GATED: begin
            step = ptick & (in_s[i] == c[`GPTU_F_GLVL]); // see RQ6
          end
          `GPTU_M_COUNT: begin
            step = pend_reg & base_tick;
            down = pdown_reg;
          end
          default: begin
            step = pend_reg & base_tick;
            down = pdown_reg;
          end
        endcase
        step = step & ~stopped; // see RQ3
      end

      // load sources: software write, capture of core, reload from aux
      always @(*) begin
        load     = wr_val[i];
        load_val = sw_val;
        if (!wr_val[i]) begin
          if (i == 0) begin
            load     = reload_req[1] | reload_req[2];
            load_val = reload_req[1] ? val_flat[31:16] : val_flat[47:32];
          end else begin
            load     = capt;
            load_val = val_flat[15:0];
          end
        end
      end

      gptu_cnt u_cnt (
        .clk      (clk),
        .ce       (ce),
        .srst     (srst),
        .step     (step),
        .down     (down),
        .load     (load),
        .load_val (load_val),
        .value    (val_flat[i*16 +: 16]),
        .wrap     (wrap[i])
      ); // see RQ1, RQ2
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // toggle latch, flips on every core wrap
  always @(posedge clk) begin
    if (srst) begin
      core_toggle_latch <= 1'b0;
    end else if (ce && wrap[0]) begin
      core_toggle_latch <= ~core_toggle_latch; // see RQ10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi write channel: address and data taken in either order
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                  {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wr_go = ce & ~awready & ~wready & ~bvalid;
  assign wr_hit = (awaddr_reg[1:0] == 2'h0) & (awaddr_reg <= `GPTU_A_PINS);
  assign wr_ctrl = {wr_go & (awaddr_reg == `GPTU_A_CTRL2),
                    wr_go & (awaddr_reg == `GPTU_A_CTRL1),
                    wr_go & (awaddr_reg == `GPTU_A_CTRL0)};
  assign wr_val = {wr_go & (awaddr_reg == `GPTU_A_VAL2),
                   wr_go & (awaddr_reg == `GPTU_A_VAL1),
                   wr_go & (awaddr_reg == `GPTU_A_VAL0)};

  always @(posedge clk) begin
    if (srst) begin
      awready    <= 1'b1;
      wready     <= 1'b1;
      bvalid     <= 1'b0;
      bresp      <= `GPTU_RESP_OK;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready    <= 1'b0;
        awaddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wready    <= 1'b0;
        wdata_reg <= wdata;
        wstrb_reg <= wstrb;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_hit ? `GPTU_RESP_OK : `GPTU_RESP_ERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // control and mask registers, byte lanes honoured
  always @(posedge clk) begin
    if (srst) begin
      ctrl_reg <= {3{`GPTU_CTRL_RST}};
      mask_reg <= 3'h0;
    end else if (ce) begin
      for (k = 0; k < 3; k = k + 1) begin
        if (wr_ctrl[k]) begin
          ctrl_reg[k*`GPTU_CW +: `GPTU_CW] <=
            (ctrl_reg[k*`GPTU_CW +: `GPTU_CW] & ~wmask[`GPTU_CW-1:0]) |
            (wdata_reg[`GPTU_CW-1:0] & wmask[`GPTU_CW-1:0]);
        end
      end
      if (wr_go && awaddr_reg == `GPTU_A_MASK && wstrb_reg[0]) begin
        mask_reg <= wdata_reg[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags: wrap or software set wins over write-one-to-clear
  assign stat_next =
    (stat_reg & ~({3{wr_go & (awaddr_reg == `GPTU_A_STAT) & wstrb_reg[0]}}
                  & wdata_reg[2:0]))
    | wrap // see RQ16
    | ({3{wr_go & (awaddr_reg == `GPTU_A_SET) & wstrb_reg[0]}} & wdata_reg[2:0]);

  always @(posedge clk) begin
    if (srst) begin
      stat_reg <= 3'h0;
      irq      <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_next; // see RQ15
      irq      <= |(stat_next & ((wr_go && awaddr_reg == `GPTU_A_MASK && wstrb_reg[0])
                                 ? wdata_reg[2:0] : mask_reg)); // new mask acts at once
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axi read channel
  always @(*) begin
    rd_next = 32'h00000000;
    rd_hit  = (araddr[1:0] == 2'h0);
    case (araddr)
      `GPTU_A_CTRL0: rd_next[`GPTU_CW-1:0] = ctrl_reg[`GPTU_CW-1:0];
      `GPTU_A_CTRL1: rd_next[`GPTU_CW-1:0] = ctrl_reg[2*`GPTU_CW-1:`GPTU_CW];
      `GPTU_A_CTRL2: rd_next[`GPTU_CW-1:0] = ctrl_reg[3*`GPTU_CW-1:2*`GPTU_CW];
      `GPTU_A_VAL0:  rd_next[15:0] = val_flat[15:0];
      `GPTU_A_VAL1:  rd_next[15:0] = val_flat[31:16];
      `GPTU_A_VAL2:  rd_next[15:0] = val_flat[47:32];
      `GPTU_A_STAT:  rd_next[2:0] = stat_reg;
      `GPTU_A_MASK:  rd_next[2:0] = mask_reg;
      `GPTU_A_SET:   rd_next = 32'h00000000;
      `GPTU_A_PINS:  rd_next[6:0] = {dir_s, in_s, core_toggle_latch};
      default:       rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `GPTU_RESP_OK;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rd_next;
        rresp   <= rd_hit ? `GPTU_RESP_OK : `GPTU_RESP_ERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire
